// *** dma_chan_ctrl.sv ***
// Request recognition, suspend and abort control of one DMA channel.
// Assumes a same-clock bus engine that runs each cycle on cyc_req until
// cyc_done, and pins req_n, control line and exception code arriving asynchronously.
`timescale 1ns/100ps
`default_nettype none
module dma_chan_ctrl
  import dma_chan_pkg::*;
#(
  parameter int DATA_W  = DATA_W_DEF,
  parameter int COUNT_W = COUNT_W_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               req_n,
  input  wire logic               peripheral_control_line_n,
  input  wire logic [2:0]         bus_exception_code,
  input  wire logic               level_request,
  input  wire logic               dual_address,
  input  wire logic               mem_to_dev,
  input  wire logic               ctl_is_abort,
  input  wire logic               start,
  input  wire logic               software_suspend_bit,
  input  wire logic               software_abort_bit,
  input  wire logic               continue_bit,
  input  wire logic               status_clear,
  input  wire logic               transition_clear,
  input  wire logic [COUNT_W-1:0] start_count,
  input  wire logic [COUNT_W-1:0] base_transfer_count,
  input  wire logic               cyc_done,
  input  wire logic [DATA_W-1:0]  rd_data,
  output logic                    cyc_req,
  output logic                    cyc_write,
  output logic                    cyc_to_device,
  output logic                    cyc_kill,
  output logic [DATA_W-1:0]       wr_data,
  output logic                    ack_n,
  output logic                    transfer_complete_strobe_n,
  output logic                    channel_running_flag,
  output logic                    operation_complete_flag,
  output logic                    fault_flag,
  output logic                    control_line_transition_flag,
  output logic [4:0]              fault_code_register,
  output logic                    operand_lock,
  output logic [COUNT_W-1:0]      memory_transfer_count
);
  chan_state_t       state_q;
  logic              phase_q;
  logic              redo_q;
  logic              pend_q;
  logic              ignore_q;
  logic              req_prev_q;
  logic              ctl_prev_q;
  logic              req_lvl;
  logic              ctl_lvl;
  logic [2:0]        exc_s;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  pin_sync #(.W(1), .RST_VAL(REQ_PIN_IDLE)) u_req_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (req_n),
    .level (req_lvl)
  );
  pin_sync #(.W(1), .RST_VAL(CTL_PIN_IDLE)) u_ctl_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (peripheral_control_line_n),
    .level (ctl_lvl)
  );
  pin_sync #(.W(3), .RST_VAL(EXC_NORMAL)) u_exc_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (bus_exception_code),
    .level (exc_s)
  );

  // Cycle outcome decode
  logic exc_ok, exc_rst, in_cyc, end_good, end_retry, end_bus, last_phase;
  assign exc_ok     = (exc_s == EXC_NORMAL);
  assign exc_rst    = (exc_s == EXC_RESET);
  assign in_cyc     = (state_q == S_CYC);
  assign end_good   = in_cyc & cyc_done & (exc_ok | (exc_s == EXC_HALT));
  assign end_retry  = in_cyc & cyc_done & ((exc_s == EXC_RETRY) | (exc_s == EXC_RELINQ));
  assign end_bus    = in_cyc & cyc_done & (exc_s == EXC_BUS_ERR);
  assign last_phase = ~dual_address | phase_q;

  function automatic logic dev_side(input logic dual, input logic ph, input logic m2d);
    dev_side = ~dual | (ph == m2d);
  endfunction : dev_side

  // Termination and progress events
  logic start_go, start_hw_abort, hw_abort, sw_abort, wait_sw_abort;
  logic svc_begin, operand_end, last_operand, finish, any_term, flush;
  assign start_go       = (state_q == S_IDLE) & start;
  assign start_hw_abort = start_go & ctl_is_abort & control_line_transition_flag; // R17
  assign hw_abort       = (state_q != S_IDLE) & ctl_is_abort
                          & control_line_transition_flag; // R16
  assign svc_begin      = (state_q == S_ARM) & pend_q & ~software_suspend_bit // R7 R9
                          & ~software_abort_bit & ~hw_abort & ~exc_rst
                          & (~dual_address | fifo_in_ready);
  // Software aborts take effect at the next operand boundary, or in an exception wait once the code is normal; hardware aborts at once
  assign sw_abort       = (state_q == S_ARM) & software_abort_bit & ~hw_abort & ~exc_rst; // R22
  assign wait_sw_abort  = (state_q == S_EXC_WAIT) & exc_ok & software_abort_bit
                          & ~hw_abort; // R14
  assign operand_end    = end_good & last_phase & ~hw_abort & ~exc_rst;
  assign last_operand   = operand_end & (memory_transfer_count == COUNT_W'(1))
                          & ~continue_bit;
  assign finish         = last_operand;
  assign any_term       = start_hw_abort | hw_abort | sw_abort | wait_sw_abort
                          | (end_bus & ~hw_abort) | (exc_rst & (state_q != S_IDLE));
  assign flush          = any_term;

  // Channel sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      phase_q <= 1'b0;
      redo_q  <= 1'b0;
    end else if (any_term | finish) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start_go) begin
            state_q <= S_ARM;
            phase_q <= 1'b0;
          end
        end
        S_ARM: begin
          if (svc_begin) begin
            state_q <= S_ISSUE;
            phase_q <= 1'b0;
          end
        end
        S_ISSUE: state_q <= S_CYC;
        S_CYC: begin
          if (end_retry) begin
            state_q <= S_EXC_WAIT;
            redo_q  <= 1'b1;
          end else if (end_good) begin
            // A halted cycle still completed; wait before the next one
            redo_q  <= 1'b0;
            phase_q <= ~last_phase;
            if (exc_s == EXC_HALT) begin
              state_q <= S_EXC_WAIT;
            end else if (last_phase) begin
              state_q <= S_ARM;
            end else begin
              state_q <= S_ISSUE;
            end
          end
        end
        S_EXC_WAIT: begin
          // Suspend is not looked at here, so suspend never stops the operand
          if (exc_ok) begin
            if (redo_q | phase_q) begin
              state_q <= S_ISSUE; // R10 R21
            end else begin
              state_q <= S_ARM;
            end
          end
        end
      endcase
    end
  end

  // Bus cycle drive; redo reuses phase, so address, data and direction repeat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_req       <= 1'b0;
      cyc_write     <= 1'b0;
      cyc_to_device <= 1'b0;
      cyc_kill      <= 1'b0;
      ack_n         <= 1'b1;
    end else begin
      cyc_kill <= in_cyc & (hw_abort | exc_rst); // R16
      if (state_q == S_ISSUE & ~any_term) begin
        cyc_req       <= 1'b1;
        cyc_write     <= dual_address ? phase_q : mem_to_dev;
        cyc_to_device <= dev_side(dual_address, phase_q, mem_to_dev);
        ack_n         <= ~dev_side(dual_address, phase_q, mem_to_dev); // R4 R6
      end else if (cyc_done | any_term) begin
        cyc_req <= 1'b0;
        ack_n   <= 1'b1;
      end
    end
  end

  // Success strobe after a device-side cycle ends normally
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_complete_strobe_n <= 1'b1;
    end else begin
      transfer_complete_strobe_n <= ~(end_good & cyc_to_device & ~hw_abort); // R4
    end
  end

  // Request recognition
  logic req_event, recog_ok;
  assign req_event = level_request ? ~req_lvl : (req_prev_q & ~req_lvl);
  assign recog_ok  = channel_running_flag & ~ignore_q
                     & (~dual_address | (state_q == S_ARM)); // R6 R8

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_prev_q <= REQ_PIN_IDLE;
      ctl_prev_q <= CTL_PIN_IDLE;
      pend_q     <= 1'b0;
      ignore_q   <= 1'b0;
    end else begin
      req_prev_q <= req_lvl;
      ctl_prev_q <= ctl_lvl;
      if (any_term | finish) begin
        pend_q   <= 1'b0;
        ignore_q <= 1'b0;
      end else begin
        // A new request in the service cycle is kept, never more than one
        if (req_event & recog_ok & (~pend_q | svc_begin)) begin
          pend_q <= 1'b1; // R1
        end else if (svc_begin) begin
          pend_q <= 1'b0;
        end
        if (end_retry & pend_q) begin
          ignore_q <= 1'b1; // R5
        end else if (svc_begin) begin
          ignore_q <= 1'b0;
        end
      end
    end
  end

  // Operand lock keeps the arbiter on this channel across exceptions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operand_lock <= 1'b0;
    end else if (svc_begin) begin
      operand_lock <= 1'b1; // R11
    end else if (operand_end | any_term) begin
      operand_lock <= 1'b0;
    end
  end

  // Channel status
  logic clt_set;
  assign clt_set = ctl_prev_q & ~ctl_lvl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_running_flag         <= 1'b0;
      operation_complete_flag      <= 1'b0;
      fault_flag                   <= 1'b0;
      control_line_transition_flag <= 1'b0;
      fault_code_register          <= FAULT_NONE;
    end else begin
      // Edge only counts when the line acts as abort; set beats clear
      if (clt_set & ctl_is_abort) begin
        control_line_transition_flag <= 1'b1; // R15
      end else if (transition_clear) begin
        control_line_transition_flag <= 1'b0;
      end
      if (start_go & ~start_hw_abort) begin
        channel_running_flag <= 1'b1;
      end else if (any_term | finish) begin
        channel_running_flag <= 1'b0; // R12
      end
      if (any_term | finish) begin
        operation_complete_flag <= 1'b1; // R12
      end else if (status_clear) begin
        operation_complete_flag <= 1'b0;
      end
      if (any_term & ~exc_rst) begin
        fault_flag <= 1'b1;
      end else if (status_clear) begin
        fault_flag <= 1'b0;
      end
      if (start_hw_abort | hw_abort) begin
        fault_code_register <= FAULT_HW_ABORT;
      end else if (sw_abort | wait_sw_abort) begin
        fault_code_register <= FAULT_SW_ABORT; // R13
      end else if (end_bus) begin
        fault_code_register <= FAULT_BUS_ERR;
      end else if (start_go) begin
        fault_code_register <= FAULT_NONE;
      end
    end
  end

  // Transfer count; left as is on abort, so not meaningful afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_transfer_count <= '0;
    end else if (start_go) begin // R18
      memory_transfer_count <= start_count;
    end else if (operand_end) begin
      if (memory_transfer_count == COUNT_W'(1) & continue_bit) begin
        memory_transfer_count <= base_transfer_count; // R19
      end else begin
        memory_transfer_count <= memory_transfer_count - COUNT_W'(1);
      end
    end
  end

  // Read data waits in the FIFO for the write half; dropped on abort
  logic push, pop;
  assign push = end_good & dual_address & ~phase_q & ~hw_abort;
  assign pop  = (state_q == S_ISSUE) & dual_address & phase_q & fifo_out_valid;

  op_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush), // R14
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_data <= '0;
    end else if (pop) begin
      wr_data <= fifo_out_data;
    end
  end
endmodule : dma_chan_ctrl
`default_nettype wire

// *** dma_chan_pkg.sv ***
// Constants and types shared by the DMA channel control block.
// Assumes a single 250 MHz clock and an active-high asynchronous reset.
// Notes on behaviour
// [R1] At most one transfer request is held pending per channel.
// [R2] Peripheral waits for one acknowledge before raising its next request.
// [R3] Peripheral counts only transfer-complete strobes as finished cycles.
// [R4] Acknowledge marks start of service; complete strobe marks success.
// [R5] After retry with a request pending, new requests are ignored until service.
// [R6] Acknowledge once per device cycle; dual mode samples requests at boundaries.
// [R7] Suspend keeps the channel running but stops new operand service.
// [R8] While suspended one request may still become pending.
// [R9] Clearing suspend resumes service of the pending request.
// [R10] An operand interrupted by halt or relinquish finishes before suspend applies.
// [R11] The operand lock holds other channels off until the operand is complete.
// [R12] Software abort stops the run, clears running, sets complete and fault.
// [R13] Software abort is recorded in the fault code.
// [R14] Abort during an interrupted operand waits for normal code, then drops data.
// [R15] A falling control line edge sets the transition flag when set as abort.
// [R16] Transition flag with abort config kills the run and any bus cycle.
// [R17] Starting with the transition flag already set aborts before any operand.
// [R18] Address and count contents are undefined after a hardware abort.
// [R19] Continue mode reloads count from base; device side stays untouched.
// [R20] External logic reports bus exceptions on a three-bit code.
// [R21] A retried cycle is repeated with identical address, data and control.
// [R22] Suspend and abort bits are sampled at every operand boundary.
package dma_chan_pkg;

  // Bus exception codes
  localparam logic [2:0] EXC_NORMAL  = 3'h0;
  localparam logic [2:0] EXC_HALT    = 3'h1;
  localparam logic [2:0] EXC_BUS_ERR = 3'h2;
  localparam logic [2:0] EXC_RETRY   = 3'h3;
  localparam logic [2:0] EXC_RELINQ  = 3'h4;
  localparam logic [2:0] EXC_RESET   = 3'h7;

  // Fault code values
  localparam logic [4:0] FAULT_NONE     = 5'h00;
  localparam logic [4:0] FAULT_BUS_ERR  = 5'h09;
  localparam logic [4:0] FAULT_SW_ABORT = 5'h11;
  localparam logic [4:0] FAULT_HW_ABORT = 5'h10;

  // Idle levels of the synchronised pins
  localparam logic       REQ_PIN_IDLE = 1'h1;
  localparam logic       CTL_PIN_IDLE = 1'h1;

  localparam int         DATA_W_DEF  = 16;
  localparam int         COUNT_W_DEF = 16;
  localparam int         FIFO_DEPTH  = 8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ARM,
    S_ISSUE,
    S_CYC,
    S_EXC_WAIT
  } chan_state_t;

endpackage : dma_chan_pkg

// *** dma_chan_props.sv ***
// Port-level assertions for the DMA channel control block.
// Assumes it is bound into dma_chan_ctrl and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module dma_chan_props
  import dma_chan_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       peripheral_control_line_n,
  input wire logic       ctl_is_abort,
  input wire logic       start,
  input wire logic       software_suspend_bit,
  input wire logic       cyc_done,
  input wire logic       cyc_req,
  input wire logic       ack_n,
  input wire logic       transfer_complete_strobe_n,
  input wire logic       channel_running_flag,
  input wire logic       operation_complete_flag,
  input wire logic       fault_flag,
  input wire logic       control_line_transition_flag,
  input wire logic [4:0] fault_code_register,
  input wire logic       operand_lock
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_ACK_IN_CYCLE: assert property (!ack_n |-> cyc_req)
    else $error("ack outside a cycle");
  AST_TCS_AFTER_DONE: assert property ($fell(transfer_complete_strobe_n) |->
    $past(cyc_done) && !$past(ack_n))
    else $error("strobe without good device cycle");
  AST_TCS_PULSE: assert property (!transfer_complete_strobe_n |=>
    transfer_complete_strobe_n)
    else $error("strobe longer than one cycle");
  // Lock guards an operand already under way, which may finish
  AST_SUSPEND_HOLD: assert property ((software_suspend_bit && !operand_lock)[*3] |->
    !$rose(cyc_req))
    else $error("service while suspended");
  AST_SW_ABORT_FLAGS: assert property ($rose(fault_code_register == FAULT_SW_ABORT) |->
    !channel_running_flag && operation_complete_flag && fault_flag)
    else $error("abort flags wrong");
  AST_END_COMPLETE: assert property ($fell(channel_running_flag) |->
    operation_complete_flag)
    else $error("run ended without complete");
  AST_HW_ABORT_STOP: assert property (ctl_is_abort && control_line_transition_flag &&
    channel_running_flag |=> !channel_running_flag)
    else $error("hardware abort not honoured");
  AST_START_FLAGGED: assert property (start && !channel_running_flag && ctl_is_abort &&
    control_line_transition_flag |=> !channel_running_flag && fault_flag &&
    fault_code_register == FAULT_HW_ABORT)
    else $error("flagged start not aborted");
  AST_CLT_SET: assert property (ctl_is_abort && $fell(peripheral_control_line_n) |->
    ##[1:10] control_line_transition_flag)
    else $error("transition flag not set");

  cover property ($fell(transfer_complete_strobe_n));
  cover property ($rose(fault_code_register == FAULT_SW_ABORT));
  cover property ($rose(control_line_transition_flag));
endmodule : dma_chan_props

bind dma_chan_ctrl dma_chan_props u_props (
  .clk(clk), .rst(rst), .peripheral_control_line_n(peripheral_control_line_n),
  .ctl_is_abort(ctl_is_abort), .start(start), .software_suspend_bit(software_suspend_bit),
  .cyc_done(cyc_done), .cyc_req(cyc_req), .ack_n(ack_n),
  .transfer_complete_strobe_n(transfer_complete_strobe_n),
  .channel_running_flag(channel_running_flag),
  .operation_complete_flag(operation_complete_flag), .fault_flag(fault_flag),
  .control_line_transition_flag(control_line_transition_flag),
  .fault_code_register(fault_code_register), .operand_lock(operand_lock)
);
`default_nettype wire

// *** dma_channel_request_and_abort_control_test.sv ***
// Self-checking bench for the DMA channel control block.
// Assumes dma_chan_ctrl, its checker and dma_far_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_request_and_abort_control_test
  import dma_chan_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, ctl_n = 1'b1, m2d = 1'b1;
  logic        lvl = 1'b0, dual = 1'b0, ctl_abt = 1'b0, start = 1'b0, susp = 1'b0;
  logic        abrt = 1'b0, cont = 1'b0, sclr = 1'b0, tclr = 1'b0, req_go = 1'b0;
  logic        cyc_done, req_n, cyc_req, cyc_write, cyc_kill, ack_n, tcs_n;
  logic        run, cmpl, flt, clt, lock;
  logic [2:0]  exc = EXC_NORMAL;
  logic [4:0]  code;
  logic [7:0]  lat = 8'h03, ack_cnt, tcs_cnt, a0, d0;
  logic [15:0] scnt = 16'h0001, bcnt = 16'h0005;
  logic [15:0] rd_data, wr_data, mcnt, rd_sent, wr_seen;
  int          fail_count = 0, cmp_count = 0;

  dma_chan_ctrl dut (
    .clk(clk), .rst(rst), .req_n(req_n), .peripheral_control_line_n(ctl_n),
    .bus_exception_code(exc), .level_request(lvl), .dual_address(dual),
    .mem_to_dev(m2d), .ctl_is_abort(ctl_abt), .start(start),
    .software_suspend_bit(susp), .software_abort_bit(abrt), .continue_bit(cont),
    .status_clear(sclr), .transition_clear(tclr), .start_count(scnt),
    .base_transfer_count(bcnt), .cyc_done(cyc_done), .rd_data(rd_data),
    .cyc_req(cyc_req), .cyc_write(cyc_write), .cyc_to_device(), .cyc_kill(cyc_kill),
    .wr_data(wr_data), .ack_n(ack_n), .transfer_complete_strobe_n(tcs_n),
    .channel_running_flag(run), .operation_complete_flag(cmpl), .fault_flag(flt),
    .control_line_transition_flag(clt), .fault_code_register(code),
    .operand_lock(lock), .memory_transfer_count(mcnt));

  dma_far_model far (
    .clk(clk), .rst(rst), .lat(lat), .req_go(req_go), .cyc_req(cyc_req),
    .cyc_write(cyc_write), .cyc_kill(cyc_kill), .ack_n(ack_n), .tcs_n(tcs_n),
    .wr_data(wr_data), .cyc_done(cyc_done), .rd_data(rd_data), .req_n(req_n),
    .ack_cnt(ack_cnt), .tcs_cnt(tcs_cnt), .rd_sent(rd_sent), .wr_seen(wr_seen));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic go(input logic [15:0] n, input logic [7:0] l);
    @(posedge clk);
    lat <= l;
    scnt <= n;
    sclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    a0 = ack_cnt;
    d0 = tcs_cnt;
    tick(2);
  endtask : go

  task automatic ask();
    @(posedge clk);
    req_go <= 1'b1;
    @(posedge clk);
    req_go <= 1'b0;
  endtask : ask

  task automatic wait_ack(input logic v);
    for (int i = 0; i < 300 && ack_n !== v; i++) @(negedge clk);
    if (ack_n !== v) begin
      fail_count++;
      $display("Error ack_n expected %0b seen %0b", v, ack_n);
      complete_run();
    end
  endtask : wait_ack

  task automatic kill_sw();
    @(posedge clk);
    abrt <= 1'b1;
    tick(6);
    @(posedge clk);
    abrt <= 1'b0;
  endtask : kill_sw

  task automatic t_single();
    go(16'h0002, 8'h03);
    chk("running", 1, run);
    ask();
    tick(30);
    chk("acks", 1, ack_cnt - a0);
    chk("strobes", 1, tcs_cnt - d0);
    chk("count", 1, mcnt);
    chk("lock", 0, lock);
    ask();
    tick(30);
    chk("running", 0, run);
    chk("complete", 1, cmpl);
    chk("fault", 0, flt);
  endtask : t_single

  task automatic t_suspend();
    go(16'h0001, 8'h03);
    @(posedge clk);
    susp <= 1'b1;
    tick(4);
    ask();
    tick(30);
    chk("acks", 0, ack_cnt - a0);
    chk("running", 1, run);
    @(posedge clk);
    susp <= 1'b0;
    tick(30);
    chk("acks", 1, ack_cnt - a0);
    chk("complete", 1, cmpl);
  endtask : t_suspend

  task automatic t_sw_abort();
    go(16'h0004, 8'h03);
    kill_sw();
    chk("running", 0, run);
    chk("complete", 1, cmpl);
    chk("fault", 1, flt);
    chk("code", FAULT_SW_ABORT, code);
  endtask : t_sw_abort

  task automatic t_retry();
    go(16'h0002, 8'h0C);
    ask();
    wait_ack(1'b0);
    @(posedge clk);
    exc <= EXC_RETRY;
    wait_ack(1'b1);
    tick(3);
    @(posedge clk);
    exc <= EXC_NORMAL;
    tick(40);
    chk("acks", 2, ack_cnt - a0);
    chk("strobes", 1, tcs_cnt - d0);
    chk("count", 1, mcnt);
    kill_sw();
  endtask : t_retry

  task automatic t_dual();
    @(posedge clk);
    dual <= 1'b1;
    go(16'h0001, 8'h02);
    ask();
    tick(40);
    chk("acks", 1, ack_cnt - a0);
    chk("strobes", 1, tcs_cnt - d0);
    chk("wr_data", rd_sent, wr_seen);
    chk("complete", 1, cmpl);
    @(posedge clk);
    dual <= 1'b0;
  endtask : t_dual

  task automatic t_hw_abort();
    @(posedge clk);
    ctl_abt <= 1'b1;
    go(16'h0003, 8'h14);
    ask();
    wait_ack(1'b0);
    @(posedge clk);
    ctl_n <= 1'b0;
    tick(12);
    chk("transition", 1, clt);
    chk("running", 0, run);
    chk("code", FAULT_HW_ABORT, code);
    chk("strobes", 0, tcs_cnt - d0);
    @(posedge clk);
    ctl_n <= 1'b1;
    go(16'h0003, 8'h03);
    chk("running", 0, run);
    chk("fault", 1, flt);
    @(posedge clk);
    tclr <= 1'b1;
    @(posedge clk);
    tclr <= 1'b0;
    ctl_abt <= 1'b0;
    tick(2);
    chk("transition", 0, clt);
  endtask : t_hw_abort

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(6);
    t_single();
    t_suspend();
    t_sw_abort();
    t_retry();
    t_dual();
    t_hw_abort();
    complete_run();
  end
endmodule : dma_channel_request_and_abort_control_test
`default_nettype wire

// *** dma_far_model.sv ***
// Far side: a bus engine ending cycles and a requesting peripheral.
// Assumes the channel's clock and reset; answer latency set by the bench.
`timescale 1ns/100ps
`default_nettype none
module dma_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  lat,
  input  wire logic        req_go,
  input  wire logic        cyc_req,
  input  wire logic        cyc_write,
  input  wire logic        cyc_kill,
  input  wire logic        ack_n,
  input  wire logic        tcs_n,
  input  wire logic [15:0] wr_data,
  output logic             cyc_done,
  output logic      [15:0] rd_data,
  output logic             req_n,
  output logic      [7:0]  ack_cnt,
  output logic      [7:0]  tcs_cnt,
  output logic      [15:0] rd_sent,
  output logic      [15:0] wr_seen
);
  logic [7:0] wait_q;
  logic       ack_q;

  // Killed cycles get no answer; idle data toggles so stale values never match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q   <= 8'h00;
      cyc_done <= 1'b0;
      rd_data  <= 16'h0000;
      rd_sent  <= 16'h0000;
      wr_seen  <= 16'h0000;
    end else begin
      cyc_done <= 1'b0;
      rd_data  <= ~rd_data;
      if (!cyc_req || cyc_done || cyc_kill) begin
        wait_q <= 8'h00;
      end else if (wait_q != lat) begin
        wait_q <= wait_q + 8'h01;
      end else begin
        cyc_done <= 1'b1;
        if (cyc_write) begin
          wr_seen <= wr_data;
        end else begin
          rd_data <= rd_sent + 16'h1357;
          rd_sent <= rd_sent + 16'h1357;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_n   <= 1'b1;
      ack_q   <= 1'b1;
      ack_cnt <= 8'h00;
      tcs_cnt <= 8'h00;
    end else begin
      ack_q <= ack_n;
      if (!ack_n) begin
        req_n <= 1'b1;
      end else if (req_go) begin
        req_n <= 1'b0;
      end
      if (ack_q && !ack_n) begin
        ack_cnt <= ack_cnt + 8'h01;
      end
      if (!tcs_n) begin
        tcs_cnt <= tcs_cnt + 8'h01;
      end
    end
  end
endmodule : dma_far_model
`default_nettype wire

// *** op_fifo.sv ***
// Operand data FIFO between the read and write halves of a dual transfer.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/100ps
`default_nettype none
module op_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= nxt(wr_q);
      if (pop) rd_q <= nxt(rd_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule : op_fifo
`default_nettype wire

// *** pin_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept a change only once two stages agree
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : pin_sync
`default_nettype wire
